// >>> rtl/ppq_ctrl.v
// port policing, drop monitor select and egress queue control registers
// assumes a classic wishbone master on CORE_CLK and same-clock datapath inputs
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "ppq_defines.vh"

module ppq_ctrl (
    // clock and reset
    input wire CORE_CLK,
    input wire ARST_N,
    // wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [`PPQ_ADDR_W-1:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    // monitor count access
    input wire [`PPQ_COUNT_W-1:0] MON_COUNT,
    output reg [2:0] MON_PORT,
    output reg [1:0] MON_QUEUE,
    output reg [1:0] MON_TYPE,
    output reg MON_DROPPED_ONLY,
    // policing and drop controls
    output reg POLICE_ENABLE,
    output reg COLOUR_BLIND,
    output reg SRP_DROP_ALLOW,
    output reg COLOUR_REMAP,
    output reg COLOUR_MARK,
    output reg [1:0] NON_IP_FRAME_COLOUR,
    output reg PORT_BASED_POLICING,
    output reg DROP_ALL,
    // egress queue select
    output reg [1:0] TX_QUEUE_INDEX,
    // egress vlan id path
    input wire EGR_VALID,
    input wire EGR_DOUBLE_TAG,
    input wire [`PPQ_VID_W-1:0] EGR_OUTER_VID,
    input wire [`PPQ_VID_W-1:0] EGR_INNER_VID,
    input wire [`PPQ_VID_W-1:0] PORT_DEFAULT_VLAN_ID,
    output reg EGR_OUT_VALID,
    output reg [`PPQ_VID_W-1:0] EGR_OUT_OUTER_VID,
    output reg [`PPQ_VID_W-1:0] EGR_OUT_INNER_VID,
    output reg VID_REPLACE
);

    // ****************************************************************
    // register state
    // ****************************************************************
    reg [2:0] port_index;
    reg [1:0] queue_pointer;
    reg dropped_colour;
    reg drop_all;
    reg [1:0] packet_type;
    reg port_based;
    reg [1:0] non_ip_frame_colour;
    reg colour_mark;
    reg colour_remap;
    reg drop_srp;
    reg colour_blind;
    reg police_enable;
    reg [1:0] queue_index;
    reg vid_replace;

    wire req = WB_CYC_I & WB_STB_I;
    wire wr_take = req & WB_ACK_O & WB_WE_I;
    wire byte3_only = (WB_SEL_I == `PPQ_SEL_BYTE3);

    // ****************************************************************
    // write strobes, one per register, taken on the edge where ack is seen
    // ****************************************************************
    // the read-only count and unmapped addresses get no strobe
    wire wr_pointer = wr_take & (WB_ADR_I == `PPQ_ADR_PORT_POINTER);
    wire wr_policing = wr_take & (WB_ADR_I == `PPQ_ADR_POLICING_CTRL);
    wire wr_queue_index = wr_take & (WB_ADR_I == `PPQ_ADR_TX_QUEUE_INDEX);
    wire wr_vid_replace = wr_take & (WB_ADR_I == `PPQ_ADR_EGRESS_VID_REPLACE);

    // ****************************************************************
    // port pointer
    // ****************************************************************
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            port_index <= 3'h0;
            queue_pointer <= 2'h0;
        end else if (wr_pointer) begin
            // byte lanes not enabled keep their value
            if (WB_SEL_I[2]) begin
                port_index <= WB_DAT_I[`PPQ_PP_PORT_HI:`PPQ_PP_PORT_LO];
            end
            if (WB_SEL_I[0]) begin
                queue_pointer <= WB_DAT_I[`PPQ_PP_QUEUE_HI:`PPQ_PP_QUEUE_LO];
            end
        end
    end

    // ****************************************************************
    // policing control
    // ****************************************************************
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dropped_colour <= 1'h0;
            drop_all <= 1'h0;
            packet_type <= `PPQ_TYPE_DROPPED;
            port_based <= 1'h0;
            non_ip_frame_colour <= `PPQ_RST_NONIP_COLOUR;
            colour_mark <= 1'h0;
            colour_remap <= 1'h0;
            drop_srp <= 1'h0;
            colour_blind <= 1'h0;
            police_enable <= 1'h0;
        end else if (wr_policing) begin
            // bits 11:8 ride lane 1, bits 7:0 lane 0
            if (WB_SEL_I[1]) begin
                dropped_colour <= WB_DAT_I[`PPQ_PC_DROPPED_COLOUR];
                drop_all <= WB_DAT_I[`PPQ_PC_DROP_ALL];
                packet_type <= WB_DAT_I[`PPQ_PC_TYPE_HI:`PPQ_PC_TYPE_LO];
            end
            if (WB_SEL_I[0]) begin
                port_based <= WB_DAT_I[`PPQ_PC_PORT_BASED];
                non_ip_frame_colour <= WB_DAT_I[`PPQ_PC_NONIP_HI:`PPQ_PC_NONIP_LO];
                colour_mark <= WB_DAT_I[`PPQ_PC_COLOUR_MARK];
                colour_remap <= WB_DAT_I[`PPQ_PC_COLOUR_REMAP];
                drop_srp <= WB_DAT_I[`PPQ_PC_DROP_SRP];
                colour_blind <= WB_DAT_I[`PPQ_PC_COLOUR_BLIND];
                police_enable <= WB_DAT_I[`PPQ_PC_ENABLE];
            end
        end
    end

    // ****************************************************************
    // transmit queue index
    // ****************************************************************
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            queue_index <= `PPQ_RST_QUEUE_INDEX;
        end else if (wr_queue_index) begin
            if (byte3_only) begin
                // byte-wide access at offset 03 carries bits 7:0
                queue_index <= WB_DAT_I[`PPQ_TQ_BYTE3_LO+1:`PPQ_TQ_BYTE3_LO];
            end else if (WB_SEL_I[0]) begin
                queue_index <= WB_DAT_I[`PPQ_TQ_INDEX_HI:`PPQ_TQ_INDEX_LO];
            end
        end
    end

    // ****************************************************************
    // egress vid replace control
    // ****************************************************************
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            vid_replace <= 1'h0;
        end else if (wr_vid_replace) begin
            if (WB_SEL_I[0]) begin
                vid_replace <= WB_DAT_I[`PPQ_VR_REPLACE];
            end
        end
    end

    // ****************************************************************
    // read mux, reserved bits zero
    // ****************************************************************
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h0;
        case (WB_ADR_I)
            `PPQ_ADR_PORT_POINTER: begin
                next_rdata[`PPQ_PP_PORT_HI:`PPQ_PP_PORT_LO] = port_index;
                next_rdata[`PPQ_PP_QUEUE_HI:`PPQ_PP_QUEUE_LO] = queue_pointer;
            end
            `PPQ_ADR_POLICING_CTRL: begin
                next_rdata[`PPQ_PC_DROPPED_COLOUR] = dropped_colour;
                next_rdata[`PPQ_PC_DROP_ALL] = drop_all;
                next_rdata[`PPQ_PC_TYPE_HI:`PPQ_PC_TYPE_LO] = packet_type;
                next_rdata[`PPQ_PC_PORT_BASED] = port_based;
                next_rdata[`PPQ_PC_NONIP_HI:`PPQ_PC_NONIP_LO] = non_ip_frame_colour;
                next_rdata[`PPQ_PC_COLOUR_MARK] = colour_mark;
                next_rdata[`PPQ_PC_COLOUR_REMAP] = colour_remap;
                next_rdata[`PPQ_PC_DROP_SRP] = drop_srp;
                next_rdata[`PPQ_PC_COLOUR_BLIND] = colour_blind;
                next_rdata[`PPQ_PC_ENABLE] = police_enable;
            end
            `PPQ_ADR_MONITOR_COUNT: begin
                // count for port_index, queue_pointer and packet_type
                next_rdata = MON_COUNT;
            end
            `PPQ_ADR_TX_QUEUE_INDEX: begin
                if (byte3_only) begin
                    next_rdata[`PPQ_TQ_BYTE3_LO+1:`PPQ_TQ_BYTE3_LO] = queue_index;
                end else begin
                    next_rdata[`PPQ_TQ_INDEX_HI:`PPQ_TQ_INDEX_LO] = queue_index;
                end
            end
            `PPQ_ADR_EGRESS_VID_REPLACE: begin
                next_rdata[`PPQ_VR_REPLACE] = vid_replace;
            end
            default: begin
                next_rdata = 32'h0;
            end
        endcase
    end

    // ****************************************************************
    // wishbone answer, one wait cycle, ack dropped after one cycle
    // ****************************************************************
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_ACK_O <= 1'h0;
            WB_DAT_O <= 32'h0;
        end else begin
            // ack falls back low after each answer, so a held request is answered again every other cycle
            WB_ACK_O <= req & ~WB_ACK_O;
            // read data frozen at the edge that first sees the request, so a moving count stands with ack
            if (req & ~WB_ACK_O & ~WB_WE_I) begin
                WB_DAT_O <= next_rdata;
            end
        end
    end

    // ****************************************************************
    // control outputs to the policing, WRED and monitor datapath
    // ****************************************************************
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            MON_PORT <= 3'h0;
            MON_QUEUE <= 2'h0;
            MON_TYPE <= `PPQ_TYPE_DROPPED;
            MON_DROPPED_ONLY <= 1'h0;
            POLICE_ENABLE <= 1'h0;
            COLOUR_BLIND <= 1'h0;
            SRP_DROP_ALLOW <= 1'h0;
            COLOUR_REMAP <= 1'h0;
            COLOUR_MARK <= 1'h0;
            NON_IP_FRAME_COLOUR <= `PPQ_RST_NONIP_COLOUR;
            PORT_BASED_POLICING <= 1'h0;
            DROP_ALL <= 1'h0;
            TX_QUEUE_INDEX <= `PPQ_RST_QUEUE_INDEX;
            VID_REPLACE <= 1'h0;
        end else begin
            // datapath sees each setting one clock after the write
            MON_PORT <= port_index;
            MON_QUEUE <= queue_pointer;
            MON_TYPE <= packet_type;
            MON_DROPPED_ONLY <= dropped_colour;
            POLICE_ENABLE <= police_enable;
            // COLOUR_BLIND only follows the colour mode while policing is on
            COLOUR_BLIND <= police_enable & colour_blind;
            SRP_DROP_ALLOW <= police_enable & drop_srp;
            // remap applies in colour-aware operation only
            COLOUR_REMAP <= colour_remap & ~colour_blind;
            COLOUR_MARK <= colour_mark;
            NON_IP_FRAME_COLOUR <= non_ip_frame_colour;
            PORT_BASED_POLICING <= port_based;
            DROP_ALL <= drop_all;
            TX_QUEUE_INDEX <= queue_index;
            VID_REPLACE <= vid_replace;
        end
    end

    // ****************************************************************
    // egress vlan id replacement, one cycle through
    // ****************************************************************
    // a zero VID marks a priority-only tag and is never replaced
    wire outer_hit = vid_replace & EGR_DOUBLE_TAG & (EGR_OUTER_VID != `PPQ_VID_ZERO);
    wire inner_hit = vid_replace & ~EGR_DOUBLE_TAG & (EGR_INNER_VID != `PPQ_VID_ZERO);

    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            EGR_OUT_VALID <= 1'h0;
            EGR_OUT_OUTER_VID <= `PPQ_VID_ZERO;
            EGR_OUT_INNER_VID <= `PPQ_VID_ZERO;
        end else begin
            EGR_OUT_VALID <= EGR_VALID;
            if (EGR_VALID) begin
                // double tagged: outer provider tag replaced, inner kept
                EGR_OUT_OUTER_VID <= outer_hit ? PORT_DEFAULT_VLAN_ID : EGR_OUTER_VID;
                EGR_OUT_INNER_VID <= inner_hit ? PORT_DEFAULT_VLAN_ID : EGR_INNER_VID;
            end
        end
    end

endmodule

// >>> rtl/ppq_defines.vh
// constants for the port policing and egress queue control bank
// assumes a 32-bit wishbone slave with byte addresses on the bus
`ifndef PPQ_DEFINES_VH
`define PPQ_DEFINES_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define PPQ_ADDR_W 16
`define PPQ_ADR_PORT_POINTER 16'h0804
`define PPQ_ADR_POLICING_CTRL 16'h080c
`define PPQ_ADR_MONITOR_COUNT 16'h0810
`define PPQ_ADR_TX_QUEUE_INDEX 16'h0900
`define PPQ_ADR_EGRESS_VID_REPLACE 16'h0904

// ****************************************************************
// field positions
// ****************************************************************
`define PPQ_PP_PORT_HI 18
`define PPQ_PP_PORT_LO 16
`define PPQ_PP_QUEUE_HI 1
`define PPQ_PP_QUEUE_LO 0
`define PPQ_PC_DROPPED_COLOUR 11
`define PPQ_PC_DROP_ALL 10
`define PPQ_PC_TYPE_HI 9
`define PPQ_PC_TYPE_LO 8
`define PPQ_PC_PORT_BASED 7
`define PPQ_PC_NONIP_HI 6
`define PPQ_PC_NONIP_LO 5
`define PPQ_PC_COLOUR_MARK 4
`define PPQ_PC_COLOUR_REMAP 3
`define PPQ_PC_DROP_SRP 2
`define PPQ_PC_COLOUR_BLIND 1
`define PPQ_PC_ENABLE 0
`define PPQ_TQ_INDEX_HI 1
`define PPQ_TQ_INDEX_LO 0
`define PPQ_TQ_BYTE3_LO 24
`define PPQ_VR_REPLACE 0

// ****************************************************************
// reset values and encodings
// ****************************************************************
`define PPQ_RST_NONIP_COLOUR 2'h1
`define PPQ_RST_QUEUE_INDEX 2'h0
`define PPQ_TYPE_DROPPED 2'h0
`define PPQ_TYPE_GREEN 2'h1
`define PPQ_TYPE_YELLOW 2'h2
`define PPQ_TYPE_RED 2'h3
`define PPQ_SEL_BYTE3 4'h8
`define PPQ_VID_W 12
`define PPQ_VID_ZERO 12'h000
`define PPQ_COUNT_W 32

`endif

// >>> dv/ppq_ctrl_checker.sv
// checker for the policing and egress queue control bank
// assumes it is bound onto ppq_ctrl, one clock, async low reset
`timescale 1ns/10ps
`include "ppq_defines.vh"
module ppq_ctrl_checker (
    // clock, reset and bus
    input wire CORE_CLK, ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O,
    input wire [`PPQ_ADDR_W-1:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    // control outputs
    input wire [2:0] MON_PORT,
    input wire [1:0] MON_QUEUE, MON_TYPE, NON_IP_FRAME_COLOUR, TX_QUEUE_INDEX,
    input wire MON_DROPPED_ONLY, POLICE_ENABLE, COLOUR_BLIND, SRP_DROP_ALLOW, COLOUR_REMAP,
    input wire COLOUR_MARK, PORT_BASED_POLICING, DROP_ALL, VID_REPLACE,
    // egress vid path
    input wire EGR_VALID, EGR_DOUBLE_TAG,
    input wire [`PPQ_VID_W-1:0] EGR_OUTER_VID, EGR_INNER_VID, PORT_DEFAULT_VLAN_ID,
    input wire [`PPQ_VID_W-1:0] EGR_OUT_OUTER_VID, EGR_OUT_INNER_VID
);
    // ****************************************************************
    // write decode at the ack edge
    // ****************************************************************
    wire wr = WB_ACK_O & WB_CYC_I & WB_STB_I & WB_WE_I;
    wire pol_wr = wr && WB_ADR_I == `PPQ_ADR_POLICING_CTRL && WB_SEL_I == 4'hf;
    wire ptr_wr = wr && WB_ADR_I == `PPQ_ADR_PORT_POINTER && WB_SEL_I == 4'hf;
    wire tq_wr = wr && WB_ADR_I == `PPQ_ADR_TX_QUEUE_INDEX && (WB_SEL_I == 4'h8 || WB_SEL_I[0]);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);
    AST_ACK: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack is not a one-cycle answer");
    AST_EN: assert property (pol_wr |=> ##1 POLICE_ENABLE == $past(WB_DAT_I[0], 2))
        else $error("enable does not follow write");
    AST_BLIND: assert property (pol_wr |=> ##1 COLOUR_BLIND == $past(WB_DAT_I[0] & WB_DAT_I[1], 2))
        else $error("blind mode wrong");
    AST_SRP: assert property (pol_wr |=> ##1 SRP_DROP_ALLOW == $past(WB_DAT_I[0] & WB_DAT_I[2], 2))
        else $error("srp drop wrong");
    AST_REMAP: assert property (pol_wr |=> ##1 COLOUR_REMAP == $past(WB_DAT_I[3] & ~WB_DAT_I[1], 2))
        else $error("remap wrong");
    AST_FIELDS: assert property (pol_wr |=> ##1 {DROP_ALL, PORT_BASED_POLICING, NON_IP_FRAME_COLOUR,
        COLOUR_MARK} == $past({WB_DAT_I[10], WB_DAT_I[7:4]}, 2)) else $error("policing fields wrong");
    AST_MON: assert property (pol_wr |=> ##1 {MON_DROPPED_ONLY, MON_TYPE} == $past({WB_DAT_I[11],
        WB_DAT_I[9:8]}, 2)) else $error("monitor select wrong");
    AST_PTR: assert property (ptr_wr |=> ##1 {MON_PORT, MON_QUEUE} == $past({WB_DAT_I[18:16],
        WB_DAT_I[1:0]}, 2)) else $error("pointer wrong");
    AST_TQ: assert property (tq_wr |=> ##1 TX_QUEUE_INDEX == ($past(WB_SEL_I, 2) == 4'h8 ?
        $past(WB_DAT_I[25:24], 2) : $past(WB_DAT_I[1:0], 2))) else $error("queue index wrong");
    AST_VID: assert property (EGR_VALID && VID_REPLACE && !EGR_DOUBLE_TAG && EGR_INNER_VID != 0
        |=> EGR_OUT_INNER_VID == $past(PORT_DEFAULT_VLAN_ID)) else $error("inner vid not replaced");
    AST_OUTER: assert property (EGR_VALID && VID_REPLACE && EGR_DOUBLE_TAG && EGR_OUTER_VID != 0
        |=> EGR_OUT_OUTER_VID == $past(PORT_DEFAULT_VLAN_ID) && EGR_OUT_INNER_VID == $past(EGR_INNER_VID))
        else $error("outer vid not replaced");
endmodule

bind ppq_ctrl ppq_ctrl_checker i_chk (.*);

// >>> dv/ppq_ctrl_test.sv
// self-checking bench for the policing and egress queue control bank
// assumes ppq_ctrl and its checker are compiled before this file
`timescale 1ns/10ps
`include "ppq_defines.vh"
module ppq_ctrl_test;
    // ****************************************************************
    // signals, named as the ports they drive or are driven by
    // ****************************************************************
    logic CORE_CLK = 0, ARST_N = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
    logic [`PPQ_ADDR_W-1:0] WB_ADR_I = 16'h0;
    logic [3:0] WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0, MON_COUNT = 32'hc0de1234, WB_DAT_O, rd;
    logic WB_ACK_O, MON_DROPPED_ONLY, POLICE_ENABLE, COLOUR_BLIND, SRP_DROP_ALLOW, COLOUR_REMAP;
    logic COLOUR_MARK, PORT_BASED_POLICING, DROP_ALL, EGR_OUT_VALID, VID_REPLACE;
    logic [2:0] MON_PORT;
    logic [1:0] MON_QUEUE, MON_TYPE, NON_IP_FRAME_COLOUR, TX_QUEUE_INDEX;
    logic EGR_VALID = 0, EGR_DOUBLE_TAG = 0;
    logic [11:0] EGR_OUTER_VID = 12'h0, EGR_INNER_VID = 12'h0, PORT_DEFAULT_VLAN_ID = 12'h5a5;
    logic [11:0] EGR_OUT_OUTER_VID, EGR_OUT_INNER_VID;
    integer failures = 0, compares = 0, cycles = 0, i;
    ppq_ctrl i_dut (.*);
    initial begin
        forever #10 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures = failures + 1;
            test_done;
        end
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task test_done;
        begin
            $display("failures %0d compares %0d", failures, compares);
            if (failures == 0 && compares > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one classic cycle; read data lands in rd
    task wb(input w, input [15:0] a, input [3:0] s, input [31:0] d);
        begin
            @(posedge CORE_CLK);
            WB_CYC_I <= 1'b1;
            WB_STB_I <= 1'b1;
            WB_WE_I <= w;
            WB_ADR_I <= a;
            WB_SEL_I <= s;
            WB_DAT_I <= d;
            @(posedge CORE_CLK);
            while (WB_ACK_O !== 1'b1) @(posedge CORE_CLK);
            rd = WB_DAT_O;
            WB_CYC_I <= 1'b0;
            WB_STB_I <= 1'b0;
            // released lanes show the inverse, so stale values are never trusted
            WB_ADR_I <= ~a;
            WB_DAT_I <= ~d;
        end
    endtask
    task step;
        begin
            @(posedge CORE_CLK);
            #1;
        end
    endtask
    task pol(input [31:0] d, input [11:0] e);
        begin
            wb(1'b1, `PPQ_ADR_POLICING_CTRL, 4'hf, d);
            step;
            chk({20'h0, MON_DROPPED_ONLY, DROP_ALL, MON_TYPE, PORT_BASED_POLICING,
                NON_IP_FRAME_COLOUR, COLOUR_MARK, COLOUR_REMAP, SRP_DROP_ALLOW, COLOUR_BLIND,
                POLICE_ENABLE}, {20'h0, e});
        end
    endtask
    // one egress beat; the vid inputs go stale-inverted once released
    task egr(input t, input [11:0] o, input [11:0] n, input [11:0] eo, input [11:0] en);
        begin
            @(posedge CORE_CLK);
            EGR_VALID <= 1'b1;
            EGR_DOUBLE_TAG <= t;
            EGR_OUTER_VID <= o;
            EGR_INNER_VID <= n;
            @(posedge CORE_CLK);
            EGR_VALID <= 1'b0;
            EGR_OUTER_VID <= ~o;
            EGR_INNER_VID <= ~n;
            #1;
            chk({7'h0, EGR_OUT_VALID, EGR_OUT_OUTER_VID, EGR_OUT_INNER_VID}, {8'h1, eo, en});
        end
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge CORE_CLK);
        chk({30'h0, NON_IP_FRAME_COLOUR}, 32'h1);
        ARST_N <= 1'b1;
        wb(1'b0, `PPQ_ADR_POLICING_CTRL, 4'hf, 32'h0);
        chk(rd, 32'h20);
        wb(1'b0, `PPQ_ADR_TX_QUEUE_INDEX, 4'hf, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, `PPQ_ADR_PORT_POINTER, 4'hf, 32'h0);
        chk(rd, 32'h0);
        pol(32'hffffffff, 12'hff7);
        wb(1'b0, `PPQ_ADR_POLICING_CTRL, 4'hf, 32'h0);
        chk(rd, 32'h00000fff);
        pol(32'h00000009, 12'h009);
        pol(32'h00000006, 12'h000);
        for (i = 0; i < 4; i = i + 1) begin
            pol({22'h0, i[1:0], 8'h0}, {2'h0, i[1:0], 8'h0});
        end
        wb(1'b1, `PPQ_ADR_POLICING_CTRL, 4'h1, 32'hffffffff);
        wb(1'b0, `PPQ_ADR_POLICING_CTRL, 4'hf, 32'h0);
        chk(rd, 32'h000003ff);
        wb(1'b1, `PPQ_ADR_PORT_POINTER, 4'hf, 32'hffffffff);
        wb(1'b0, `PPQ_ADR_PORT_POINTER, 4'hf, 32'h0);
        chk(rd, 32'h00070003);
        chk({27'h0, MON_PORT, MON_QUEUE}, 32'h1f);
        wb(1'b0, `PPQ_ADR_MONITOR_COUNT, 4'hf, 32'h0);
        chk(rd, 32'hc0de1234);
        wb(1'b1, `PPQ_ADR_TX_QUEUE_INDEX, 4'h1, 32'hfffffffe);
        step;
        chk({30'h0, TX_QUEUE_INDEX}, 32'h2);
        wb(1'b1, `PPQ_ADR_TX_QUEUE_INDEX, 4'h8, 32'h03000000);
        wb(1'b0, `PPQ_ADR_TX_QUEUE_INDEX, 4'h8, 32'h0);
        chk(rd, 32'h03000000);
        wb(1'b0, `PPQ_ADR_TX_QUEUE_INDEX, 4'hf, 32'h0);
        chk(rd, 32'h3);
        wb(1'b1, 16'h0abc, 4'hf, 32'hffffffff);
        wb(1'b0, 16'h0abc, 4'hf, 32'h0);
        chk(rd, 32'h0);
        egr(1'b0, 12'h111, 12'h222, 12'h111, 12'h222);
        wb(1'b1, `PPQ_ADR_EGRESS_VID_REPLACE, 4'hf, 32'hffffffff);
        wb(1'b0, `PPQ_ADR_EGRESS_VID_REPLACE, 4'hf, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, VID_REPLACE}, 32'h1);
        egr(1'b0, 12'h111, 12'h222, 12'h111, 12'h5a5);
        egr(1'b0, 12'h111, 12'h000, 12'h111, 12'h000);
        egr(1'b1, 12'h111, 12'h222, 12'h5a5, 12'h222);
        egr(1'b1, 12'h000, 12'h222, 12'h000, 12'h222);
        // mid-run reset puts every setting back to its reset value
        @(posedge CORE_CLK);
        ARST_N <= 1'b0;
        step;
        chk({27'h0, VID_REPLACE, COLOUR_MARK, POLICE_ENABLE, TX_QUEUE_INDEX}, 32'h0);
        chk({30'h0, NON_IP_FRAME_COLOUR}, 32'h1);
        @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        wb(1'b0, `PPQ_ADR_POLICING_CTRL, 4'hf, 32'h0);
        chk(rd, 32'h20);
        wb(1'b0, `PPQ_ADR_TX_QUEUE_INDEX, 4'hf, 32'h0);
        chk(rd, 32'h0);
        test_done;
    end
endmodule
